// ===== core/pewc_defines.vh
// constants for the parallel nonvolatile memory host controller
// Operation
// - host pulses write strobe, output drive high
// - host waits for completion before access
// - bulk clear: high voltage, 10 ms strobe
// - address bit nine high maps id bytes
`ifndef PEWC_DEFINES_VH
`define PEWC_DEFINES_VH
`define PEWC_ADDR_W        13
`define PEWC_DATA_W        8
`define PEWC_CLK_MHZ       125
`define PEWC_PROG_US       200
`define PEWC_PROG_CYC      (`PEWC_PROG_US * `PEWC_CLK_MHZ)
`define PEWC_PWRUP_MS      5
`define PEWC_PWRUP_CYC     (`PEWC_PWRUP_MS * 1000 * `PEWC_CLK_MHZ)
`define PEWC_CLEAR_MS      10
`define PEWC_CLEAR_CYC     (`PEWC_CLEAR_MS * 1000 * `PEWC_CLK_MHZ)
`define PEWC_SETUP_NS      16
`define PEWC_SETUP_CYC     ((`PEWC_SETUP_NS + 7) / 8)
`define PEWC_PULSE_NS      104
`define PEWC_PULSE_CYC     ((`PEWC_PULSE_NS + 7) / 8)
`define PEWC_READ_NS       128
`define PEWC_READ_CYC      ((`PEWC_READ_NS + 7) / 8)
`define PEWC_HVS_US        1
`define PEWC_HVS_CYC       (`PEWC_HVS_US * `PEWC_CLK_MHZ)
`define PEWC_ID_BASE       13'h1FE0
`define PEWC_CNT_W         24
`endif

// ===== core/pewc_host.v
// host controller driving a byte-wide self-timed nonvolatile memory
`include "pewc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module pewc_host #(
    parameter [23:0] PROG_TIMEOUT = `PEWC_PROG_CYC,
    parameter [23:0] PWRUP_CYC    = `PEWC_PWRUP_CYC,
    parameter [23:0] CLEAR_CYC    = `PEWC_CLEAR_CYC,
    parameter [23:0] HV_CYC       = `PEWC_HVS_CYC
) (
    input  wire        i_ref_clk,
    input  wire        i_reset_n,
    input  wire        i_req,
    input  wire [1:0]  i_cmd,
    input  wire [12:0] i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_id_area,
    input  wire        i_supply_ok,
    input  wire [7:0]  i_data_bus,
    input  wire        i_ready_line,
    output reg         o_busy,
    output reg         o_done,
    output reg  [7:0]  o_rdata,
    output reg         o_timeout,
    output reg  [12:0] o_address_bus,
    output reg  [7:0]  o_data_bus,
    output reg         o_data_bus_oe_n,
    output reg         o_chip_sel_n,
    output reg         o_out_drv_n,
    output reg         o_write_n,
    output reg         o_out_drv_hv,
    output reg         o_address_bit_nine_hv
);
    // ----------------------------------------------------------------
    // states and commands
    // ----------------------------------------------------------------
    localparam [1:0] CMD_READ  = 2'h0;
    localparam [1:0] CMD_WRITE = 2'h1;
    localparam [1:0] CMD_CLEAR = 2'h2;
    localparam [3:0] ST_PWRUP = 4'h0;
    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_SETUP = 4'h2;
    localparam [3:0] ST_RDWT  = 4'h3;
    localparam [3:0] ST_WPUL  = 4'h4;
    localparam [3:0] ST_WHOLD = 4'h5;
    localparam [3:0] ST_POLL  = 4'h6;
    localparam [3:0] ST_PREC  = 4'h7;
    localparam [3:0] ST_HVUP  = 4'h8;
    localparam [3:0] ST_CPUL  = 4'h9;
    localparam [3:0] ST_HVDN  = 4'hA;
    localparam [3:0] ST_END   = 4'hB;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    reg [7:0] data_s1;
    reg [7:0] data_s2;
    reg       rdy_s1;
    reg       rdy_s2;
    reg       sup_s1;
    reg       sup_s2;
    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            data_s1 <= 8'h00;
            data_s2 <= 8'h00;
            rdy_s1  <= 1'b0;
            rdy_s2  <= 1'b0;
            sup_s1  <= 1'b0;
            sup_s2  <= 1'b0;
        end else begin
            data_s1 <= i_data_bus;
            data_s2 <= data_s1;
            rdy_s1  <= i_ready_line;
            rdy_s2  <= rdy_s1;
            sup_s1  <= i_supply_ok;
            sup_s2  <= sup_s1;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    reg [3:0]  state;
    reg [23:0] cnt;
    reg [1:0]  cmd;
    reg [7:0]  wbyte;
    reg        rdy_seen;
    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_PWRUP;
            cnt <= 24'h000000;
            cmd <= 2'h0;
            wbyte <= 8'h00;
            rdy_seen <= 1'b0;
            o_busy <= 1'b1;
            o_done <= 1'b0;
            o_rdata <= 8'h00;
            o_timeout <= 1'b0;
            o_address_bus <= 13'h0000;
            o_data_bus <= 8'h00;
            o_data_bus_oe_n <= 1'b1;
            o_chip_sel_n <= 1'b1;
            o_out_drv_n <= 1'b1;
            o_write_n <= 1'b1;
            o_out_drv_hv <= 1'b0;
            o_address_bit_nine_hv <= 1'b0;
        end else begin
            o_done <= 1'b0;
            cnt <= cnt + 24'h000001;
            case (state)
            ST_PWRUP: begin
                // supply low holds writes off and restarts the wait
                if (!sup_s2) begin
                    cnt <= 24'h000000;
                end else if (cnt >= PWRUP_CYC - 24'h000001) begin
                    state <= ST_IDLE;
                    o_busy <= 1'b0;
                end
            end
            ST_IDLE: begin
                cnt <= 24'h000000;
                if (!sup_s2) begin
                    state <= ST_PWRUP;
                    o_busy <= 1'b1;
                end else if (i_req && i_cmd != 2'h3) begin
                    cmd <= i_cmd;
                    wbyte <= i_wdata;
                    o_busy <= 1'b1;
                    o_timeout <= 1'b0;
                    o_address_bus <= i_addr;
                    o_data_bus <= i_wdata;
                    o_address_bit_nine_hv <= i_id_area;
                    o_chip_sel_n <= 1'b0;
                    if (i_cmd == CMD_CLEAR) begin
                        o_out_drv_n <= 1'b1;
                        state <= ST_HVUP;
                    end else begin
                        state <= ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                if (cnt >= `PEWC_SETUP_CYC - 1) begin
                    cnt <= 24'h000000;
                    if (cmd == CMD_READ) begin
                        o_out_drv_n <= 1'b0;
                        state <= ST_RDWT;
                    end else begin
                        // output drive stays high so the strobe starts a write
                        o_write_n <= 1'b0;
                        o_data_bus_oe_n <= 1'b0;
                        state <= ST_WPUL;
                    end
                end
            end
            ST_RDWT: begin
                if (cnt >= `PEWC_READ_CYC - 1) begin
                    o_rdata <= data_s2;
                    o_out_drv_n <= 1'b1;
                    cnt <= 24'h000000;
                    state <= ST_END;
                end
            end
            ST_WPUL: begin
                if (cnt >= `PEWC_PULSE_CYC - 1) begin
                    o_write_n <= 1'b1;
                    cnt <= 24'h000000;
                    state <= ST_WHOLD;
                end
            end
            ST_WHOLD: begin
                // bus released once the byte is latched inside
                o_data_bus_oe_n <= 1'b1;
                o_out_drv_n <= 1'b0;
                rdy_seen <= 1'b0;
                cnt <= 24'h000000;
                state <= ST_POLL;
            end
            ST_POLL: begin
                // done when ready line released and bit seven reads true
                if (!rdy_s2) rdy_seen <= 1'b1;
                if (cnt > `PEWC_READ_CYC && rdy_s2 &&
                    data_s2[7] == wbyte[7]) begin
                    o_rdata <= data_s2;
                    o_out_drv_n <= 1'b1;
                    cnt <= 24'h000000;
                    state <= ST_END;
                end else if (cnt >= PROG_TIMEOUT) begin
                    o_timeout <= 1'b1;
                    o_out_drv_n <= 1'b1;
                    cnt <= 24'h000000;
                    state <= ST_END;
                end
            end
            ST_HVUP: begin
                o_out_drv_hv <= 1'b1;
                if (cnt >= HV_CYC - 24'h000001) begin
                    o_write_n <= 1'b0;
                    cnt <= 24'h000000;
                    state <= ST_CPUL;
                end
            end
            ST_CPUL: begin
                if (cnt >= CLEAR_CYC - 24'h000001) begin
                    o_write_n <= 1'b1;
                    cnt <= 24'h000000;
                    state <= ST_HVDN;
                end
            end
            ST_HVDN: begin
                if (cnt >= HV_CYC - 24'h000001) begin
                    o_out_drv_hv <= 1'b0;
                    cnt <= 24'h000000;
                    state <= ST_END;
                end
            end
            ST_END: begin
                o_chip_sel_n <= 1'b1;
                o_address_bit_nine_hv <= 1'b0;
                o_done <= 1'b1;
                cnt <= 24'h000000;
                state <= ST_PREC;
            end
            ST_PREC: begin
                // one idle cycle keeps the device deselected between accesses
                o_busy <= 1'b0;
                state <= ST_IDLE;
            end
            default: begin
                state <= ST_IDLE;
                o_busy <= 1'b0;
            end
            endcase
        end
    end
endmodule // pewc_host
`default_nettype wire

// ===== testbench/pewc_checker.sv
// assertions on the host controller's memory-side strobes
`timescale 1ns/1ps
`default_nettype none
module pewc_checker #(parameter int CLEAR_CYC = 30) (
    input wire logic       i_ref_clk,
    input wire logic       i_reset_n,
    input wire logic       i_req,
    input wire logic [1:0] i_cmd,
    input wire logic       i_supply_ok,
    input wire logic       o_busy,
    input wire logic       o_done,
    input wire logic       o_timeout,
    input wire logic       o_data_bus_oe_n,
    input wire logic       o_chip_sel_n,
    input wire logic       o_out_drv_n,
    input wire logic       o_write_n,
    input wire logic       o_out_drv_hv
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    int low_cnt;
    // length of the current strobe low time, read at its rising edge
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
        if (!i_reset_n) low_cnt <= 0;
        else low_cnt <= o_write_n ? 0 : low_cnt + 1;
    AST_NO_FIGHT: assert property (!o_data_bus_oe_n |-> o_out_drv_n)
        else $error("data bus driven by both sides");
    AST_WR_LEVELS: assert property (!o_write_n |-> !o_chip_sel_n && (o_out_drv_n || o_out_drv_hv))
        else $error("write strobe low with wrong levels");
    AST_WR_PULSE: assert property ($fell(o_write_n) && !o_out_drv_hv |-> !o_write_n[*8] ##1 !o_write_n[*5] ##1 o_write_n)
        else $error("write pulse not 13 cycles");
    AST_DATA_RISE: assert property ($rose(o_write_n) && !o_out_drv_hv |-> !o_data_bus_oe_n && !o_chip_sel_n)
        else $error("data not driven at strobe rise");
    AST_CLEAR_LEN: assert property ($rose(o_write_n) && o_out_drv_hv |-> low_cnt >= CLEAR_CYC && !o_chip_sel_n)
        else $error("clear strobe too short");
    // the controller sees supply sense two edges late through its synchroniser
    AST_TAKE: assert property (!o_busy && i_req && i_cmd != 2'h3 && $past(i_supply_ok, 2) |=> o_busy && !o_chip_sel_n)
        else $error("request not taken");
    AST_SKIP: assert property (!o_busy && i_req && i_cmd == 2'h3 && $past(i_supply_ok, 2) |=> !o_busy && o_chip_sel_n)
        else $error("ignored command started access");
    AST_DONE_END: assert property (o_done |-> o_busy && o_chip_sel_n ##1 !o_busy)
        else $error("done without release");
    AST_READ_SEL: assert property ($fell(o_out_drv_n) |-> !o_chip_sel_n && o_write_n)
        else $error("output drive low outside a read");
    cover property (o_done && o_timeout);
    cover property ($rose(o_write_n) && o_out_drv_hv);
    cover property ($fell(o_out_drv_n));
endmodule // pewc_checker
bind pewc_host pewc_checker #(.CLEAR_CYC(CLEAR_CYC)) pewc_checker_inst (.*);
`default_nettype wire

// ===== testbench/pewc_mem_model.sv
// behavioural byte-wide self-timed memory on the host's pins
`timescale 1ns/1ps
`default_nettype none
// PWRUP_NS is a shortened power-up wait so the bench stays short
module pewc_mem_model #(parameter int PROG_NS = 1000,
                        parameter int PWRUP_NS = 100) (
    input  wire logic [12:0] i_addr,
    input  wire logic [7:0]  i_din,
    input  wire logic        i_cs_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_hv,
    input  wire logic        i_a9_hv,
    input  wire logic        i_supply_ok,
    input  wire logic        i_slow,
    output logic      [7:0]  o_dq,
    output logic             o_busy_low
);
    logic [7:0]  mem [0:8223];
    logic [7:0]  last = 8'hFF;
    logic [7:0]  wd = 8'h00;
    logic [13:0] wa = 14'h0000;
    logic        arm = 1'b0;
    time         sup_rise = 0;
    // writes stay locked out until the supply has been good a while
    always @(posedge i_supply_ok) sup_rise = $time;
    wire logic   rd = !i_cs_n && !i_oe_n && i_we_n && !i_oe_hv;
    wire [13:0]  ra = (i_a9_hv && i_addr >= 13'h1FE0) ? {9'h100, i_addr[4:0]} : {1'h0, i_addr};
    // a busy read shows only the inverted bit seven; the rest is junk
    wire [7:0]   drv = o_busy_low ? {~wd[7], 7'h2A} : mem[ra];
    // a floating bus must not look like a held value
    assign o_dq = rd ? drv : ~last;
    always @* if (rd) last = drv;
    initial begin
        o_busy_low = 1'b0;
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    always @(negedge i_we_n) begin
        arm = !i_cs_n && (i_oe_n || i_oe_hv) && i_supply_ok && !o_busy_low
              && ($time - sup_rise >= PWRUP_NS);
        if (arm) wa = ra;
    end
    // the process sleeps while programming, so later strobes are lost
    always @(posedge i_we_n)
        if (arm && i_oe_hv) begin
            foreach (mem[i]) mem[i] = 8'hFF;
        end else if (arm) begin
            wd = i_din;
            o_busy_low = 1'b1;
            mem[wa] = 8'hFF;
            #(i_slow ? 3 * PROG_NS : PROG_NS);
            mem[wa] = wd;
            o_busy_low = 1'b0;
        end
endmodule // pewc_mem_model
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench: host controller against the memory model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {logic [1:0] c; logic [12:0] a; logic [7:0] d; logic i; logic [7:0] e;} pewc_row_t;
    logic        clk = 0, rst_n = 0, req = 0, id = 0, sup = 1, slow = 0;
    logic [1:0]  cmd = 2'h0;
    logic [12:0] addr = 13'h0000, a_bus;
    logic [7:0]  wd = 8'h00, rdata, h_d, dq;
    logic        busy, done, tmo, oe_n, cs_n, od_n, we_n, od_hv, a9_hv, bl;
    int          mismatches = 0, num_checks = 0;
    wire [7:0]   bus = oe_n ? dq : h_d;
    pewc_row_t   rows [8] = '{'{2'h1, 13'h0000, 8'hA5, 1'b0, 8'hA5}, '{2'h0, 13'h0000, 8'h00, 1'b0, 8'hA5},
        '{2'h1, 13'h1FFF, 8'h3C, 1'b0, 8'h3C}, '{2'h0, 13'h1FFF, 8'h00, 1'b0, 8'h3C},
        '{2'h1, 13'h1FE0, 8'h5A, 1'b1, 8'h5A}, '{2'h0, 13'h1FE0, 8'h00, 1'b1, 8'h5A},
        '{2'h0, 13'h1FE0, 8'h00, 1'b0, 8'hFF}, '{2'h1, 13'h0001, 8'h7F, 1'b0, 8'h7F}};
    pewc_host #(.PROG_TIMEOUT(24'hC8), .PWRUP_CYC(24'h14), .CLEAR_CYC(24'h1E), .HV_CYC(24'h4)) pewc_host_inst (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_cmd(cmd), .i_addr(addr), .i_wdata(wd),
        .i_id_area(id), .i_supply_ok(sup), .i_data_bus(bus), .i_ready_line(!bl), .o_busy(busy),
        .o_done(done), .o_rdata(rdata), .o_timeout(tmo), .o_address_bus(a_bus), .o_data_bus(h_d),
        .o_data_bus_oe_n(oe_n), .o_chip_sel_n(cs_n), .o_out_drv_n(od_n), .o_write_n(we_n),
        .o_out_drv_hv(od_hv), .o_address_bit_nine_hv(a9_hv));
    pewc_mem_model pewc_mem_model_inst (.i_addr(a_bus), .i_din(bus), .i_cs_n(cs_n), .i_oe_n(od_n),
        .i_we_n(we_n), .i_oe_hv(od_hv), .i_a9_hv(a9_hv), .i_supply_ok(sup), .i_slow(slow),
        .o_dq(dq), .o_busy_low(bl));
    initial forever #4 clk = ~clk;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // bounded wait for the controller to go idle
    task automatic wait_idle;
        int n = 0;
        while (busy !== 1'b0 && n < 900) begin @(posedge clk); #1; n++; end
        if (busy !== 1'b0) begin mismatches++; end_sim(); end
    endtask
    task automatic run(input pewc_row_t r);
        int n = 0;
        cmd = r.c; addr = r.a; wd = r.d; id = r.i; req = 1'b1;
        while (busy !== 1'b1 && n < 9) begin @(posedge clk); #1; n++; end
        req = 1'b0;
        while (done !== 1'b1 && n < 900) begin @(posedge clk); #1; n++; end
        // a request that is never taken or never finishes is a failure
        if (done !== 1'b1) begin mismatches++; end_sim(); end
        wait_idle();
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        chk(8'h01, {7'h0, busy});
        wait_idle();
        foreach (rows[i]) begin
            run(rows[i]);
            chk(rows[i].e, rdata);
            $display("row %0d done", i);
        end
        run('{2'h2, 13'h0000, 8'h00, 1'b0, 8'hFF});
        run('{2'h0, 13'h0000, 8'h00, 1'b0, 8'hFF});
        chk(8'hFF, rdata);
        cmd = 2'h3; req = 1'b1;
        repeat (5) @(posedge clk);
        #1 chk(8'h00, {7'h0, busy});
        req = 1'b0; slow = 1'b1;
        run('{2'h1, 13'h0002, 8'h11, 1'b0, 8'h11});
        chk(8'h01, {7'h0, tmo});
        repeat (400) @(posedge clk);
        #1 slow = 1'b0;
        run('{2'h0, 13'h0002, 8'h00, 1'b0, 8'h11});
        chk(8'h11, rdata);
        $display("clear, skip and slow tests done");
        sup = 1'b0;
        repeat (5) @(posedge clk);
        #1 chk(8'h01, {7'h0, busy});
        sup = 1'b1;
        wait_idle();
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(8'h03, {6'h0, busy, cs_n});
        rst_n = 1'b1;
        wait_idle();
        run('{2'h0, 13'h1FFF, 8'h00, 1'b0, 8'hFF});
        chk(8'hFF, rdata);
        $display("supply and reset tests done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
